// *** sensor_rate_mode_control.sv ***
// Control and identification registers with rate selection and burst pointer.
`timescale 1ns/10ps
// Operation
// - Eight-bit read-only identifier, preproduction or production value, writes ignored.
// - Configuration fields change only in standby; active bit changes anytime.
// - Sleep rate code selects 50, 12.5, 6.25 or 1.56 Hz.
// - Auto-sleep replaces the normal output rate for every block.
// - Hybrid operation halves the sleep rate, code 00 giving 25 Hz.
// - Rate codes 000 to 111 select 800 down to 1.5625 Hz.
// - Hybrid operation halves the output rate, 400 down to 0.7813 Hz.
// - Low-noise bit doubles gain; host uses it only at 2 g or 4 g.
// - Low-noise operation limits range to 4 g; higher thresholds never trip.
// - Fast read keeps high bytes only; burst pointer skips low bytes.
// - Hybrid increment plus fast read: 6-byte burst from X high returns all.
// - Fast-read bit changes only while FIFO mode is zero.
// - Active bit selects standby at 0, active at 1; resets to 0.
// - Hybrid increment: all data in one 12-byte burst from address 0x01.
module sensor_rate_mode_control
  import rate_mode_pkg::*;
#(
  parameter logic [7:0] IDENT_PREPROD = rate_mode_pkg::IDENT_PREPROD_DEFAULT,
  parameter logic [7:0] IDENT_PROD    = rate_mode_pkg::IDENT_PROD_DEFAULT
)(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic        production_part,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic        burst_start,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic [7:0]  sensor_rdata,
  input  wire logic        fifo_mode_zero,
  input  wire logic        hybrid_mode,
  input  wire logic        hybrid_burst_increment,
  input  wire logic        auto_sleep,
  output logic      [7:0]  reg_rdata,
  output logic      [7:0]  burst_addr,
  output logic             active,
  output logic             low_noise,
  output logic             fast_read,
  output logic      [7:0]  range_limit_g,
  output logic             sample_tick
);
  import rate_mode_pkg::*;

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] prod_sync;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      prod_sync <= 2'h0;
    else if (clk_en)
      prod_sync <= {prod_sync[0], production_part};
  end

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  logic [7:0] control_one;
  logic [7:0] next_control_one;
  logic [7:0] identifier_value;

  // The identifier is a fixed strap per part kind; no write path reaches it.
  assign identifier_value = prod_sync[1] ? IDENT_PROD : IDENT_PREPROD;

  always_comb
  begin
    next_control_one = control_one;
    if (reg_write && reg_addr == ADDR_SYSTEM_CONTROL_ONE)
    begin
      next_control_one[ACTIVE_BIT] = reg_wdata[ACTIVE_BIT];
      if (!control_one[ACTIVE_BIT])
      begin
        // Fields other than active are held while sampling.
        next_control_one[7:OUT_RATE_LSB] = reg_wdata[7:OUT_RATE_LSB];
        next_control_one[LOW_NOISE_BIT] = reg_wdata[LOW_NOISE_BIT];
        if (fifo_mode_zero)
          next_control_one[FAST_READ_BIT] = reg_wdata[FAST_READ_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      control_one <= CONTROL_ONE_RESET;
    else if (clk_en)
      control_one <= next_control_one;
  end

  assign active        = control_one[ACTIVE_BIT];
  assign low_noise     = control_one[LOW_NOISE_BIT];
  assign fast_read     = control_one[FAST_READ_BIT];
  // Zero means the full range of the range setting applies.
  assign range_limit_g = low_noise ? LOW_NOISE_LIMIT_G : 8'h00;

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  logic [7:0] next_reg_rdata;
  always_comb
  begin
    next_reg_rdata = reg_rdata;
    if (reg_read)
    begin
      case (reg_addr)
        ADDR_SYSTEM_CONTROL_ONE: next_reg_rdata = control_one;
        ADDR_DEVICE_IDENTIFIER:  next_reg_rdata = identifier_value;
        default:                 next_reg_rdata = sensor_rdata;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (clk_en)
      reg_rdata <= next_reg_rdata;
  end

  // ---------------------------------------------------------------------------
  // Burst address pointer
  // ---------------------------------------------------------------------------
  // Address after a data byte; fast read steps by two to drop the low bytes,
  // and the hybrid increment wraps from the last accel byte into the mag bank.
  function automatic logic [7:0] step_addr(input logic [7:0] addr, input logic fast,
                                           input logic hyb);
    logic [7:0] last;
    logic [7:0] nxt;
    last = fast ? ADDR_ACCEL_LAST - 8'h01 : ADDR_ACCEL_LAST;
    nxt  = fast ? addr + 8'h02 : addr + 8'h01;
    if (hyb && addr == last)
      step_addr = ADDR_MAG_FIRST;
    else if (hyb && addr >= ADDR_MAG_LAST - (fast ? 8'h01 : 8'h00))
      step_addr = ADDR_OUT_X_HIGH;
    else
      step_addr = nxt;
  endfunction

  logic [7:0] next_burst_addr;
  always_comb
  begin
    next_burst_addr = burst_addr;
    if (burst_start)
      next_burst_addr = reg_addr;
    else if (reg_read)
      next_burst_addr = step_addr(burst_addr, fast_read, hybrid_mode && hybrid_burst_increment);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      burst_addr <= 8'h00;
    else if (clk_en)
      burst_addr <= next_burst_addr;
  end

  // ---------------------------------------------------------------------------
  // Sample rate generator
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] rate_cycles(input logic [7:0] ctl, input logic sleep,
                                              input logic hyb);
    logic [31:0] units;
    units = sleep ? 32'(SLEEP_PERIOD_UNITS[ctl[7:SLEEP_RATE_LSB]])
                  : 32'(OUT_PERIOD_UNITS[ctl[5:OUT_RATE_LSB]]);
    if (hyb)
      units = units << 1;
    rate_cycles = 32'(units * 32'(UNIT_CYCLES));
  endfunction

  logic [31:0] rate_count;
  logic [31:0] next_rate_count;
  logic [31:0] period;
  assign period = rate_cycles(control_one, auto_sleep, hybrid_mode);

  always_comb
  begin
    next_rate_count = rate_count;
    if (!active)
      next_rate_count = 32'h0;
    else if (rate_count + 32'h1 >= period)
      next_rate_count = 32'h0;
    else
      next_rate_count = rate_count + 32'h1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rate_count <= 32'h0;
    else if (clk_en)
      rate_count <= next_rate_count;
  end

  assign sample_tick = clk_en && active && (rate_count + 32'h1 >= period);

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  active_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && active && reg_write && reg_addr == ADDR_SYSTEM_CONTROL_ONE
    |=> control_one[7:1] == $past(control_one[7:1]))
    else $error("protected field changed while active");

  active_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && reg_write && reg_addr == ADDR_SYSTEM_CONTROL_ONE
    |=> active == $past(reg_wdata[0]))
    else $error("active bit did not follow write");

  fast_lock_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && !fifo_mode_zero |=> fast_read == $past(fast_read))
    else $error("fast read changed with fifo mode set");

  ident_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && reg_read && reg_addr == ADDR_DEVICE_IDENTIFIER
    |=> reg_rdata == ($past(prod_sync[1]) ? IDENT_PROD : IDENT_PREPROD))
    else $error("identifier read wrong");

  fast_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && reg_read && !burst_start && fast_read && !hybrid_burst_increment
    |=> burst_addr == $past(burst_addr) + 8'h02)
    else $error("fast read pointer did not skip low byte");

  hyb_wrap_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && reg_read && !burst_start && !fast_read && hybrid_mode && hybrid_burst_increment
    && burst_addr == ADDR_ACCEL_LAST |=> burst_addr == ADDR_MAG_FIRST)
    else $error("hybrid pointer did not enter magnetic bank");

  low_noise_a: assert property (@(posedge clk) disable iff (!arst_n)
    low_noise |-> range_limit_g == 8'h04)
    else $error("low noise range limit wrong");

  hyb_rate_a: assert property (@(posedge clk) disable iff (!arst_n)
    hybrid_mode |-> period == (rate_cycles(control_one, auto_sleep, 1'b0) << 1))
    else $error("hybrid rate not halved");

  standby_tick_a: assert property (@(posedge clk) disable iff (!arst_n)
    !active |-> !sample_tick)
    else $error("sample tick in standby");

  // Period expectations are written as cycle counts at 40 MHz, not through the
  // rate tables, so that a wrong table entry or a wrong index is caught here.
  // A 1.25 ms period is 50000 cycles; each slower entry doubles or quadruples it.
  sleep_fast_a: assert property (@(posedge clk) disable iff (!arst_n)
    auto_sleep && !hybrid_mode && control_one[7:6] == 2'h0
    |-> period == 32'h000C3500)
    else $error("sleep rate code zero period wrong");

  sleep_over_a: assert property (@(posedge clk) disable iff (!arst_n)
    auto_sleep && !hybrid_mode && control_one[7:6] == 2'h1
    |-> period == 32'h0030D400)
    else $error("sleep rate did not override output rate");

  sleep_slow_a: assert property (@(posedge clk) disable iff (!arst_n)
    auto_sleep && !hybrid_mode && control_one[7:6] == 2'h3
    |-> period == 32'h0186A000)
    else $error("sleep rate code three period wrong");

  sleep_hyb_a: assert property (@(posedge clk) disable iff (!arst_n)
    auto_sleep && hybrid_mode && control_one[7:6] == 2'h0
    |-> period == 32'h00186A00)
    else $error("hybrid sleep rate not halved");

  out_fast_a: assert property (@(posedge clk) disable iff (!arst_n)
    !auto_sleep && !hybrid_mode && control_one[5:3] == 3'h0
    |-> period == 32'h0000C350)
    else $error("fastest output rate period wrong");

  out_slow_a: assert property (@(posedge clk) disable iff (!arst_n)
    !auto_sleep && !hybrid_mode && control_one[5:3] == 3'h7
    |-> period == 32'h0186A000)
    else $error("slowest output rate period wrong");

  hyb_slow_a: assert property (@(posedge clk) disable iff (!arst_n)
    !auto_sleep && hybrid_mode && control_one[5:3] == 3'h7
    |-> period == 32'h030D4000)
    else $error("slowest hybrid rate period wrong");

  // A low enable must freeze every piece of state, or a paused host sees drift.
  enable_freeze_a: assert property (@(posedge clk) disable iff (!arst_n)
    !clk_en |=> control_one == $past(control_one) && burst_addr == $past(burst_addr)
    && rate_count == $past(rate_count))
    else $error("state changed with clock enable low");

  burst_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && burst_start
    |=> burst_addr == $past(reg_addr))
    else $error("burst pointer not loaded");

  fast_wrap_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && reg_read && !burst_start && fast_read && hybrid_mode && hybrid_burst_increment
    && burst_addr == 8'h05 |=> burst_addr == 8'h33)
    else $error("fast hybrid pointer did not enter magnetic bank");

  rdata_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    clk_en && !reg_read
    |=> reg_rdata == $past(reg_rdata))
    else $error("read data changed without a read");
endmodule // sensor_rate_mode_control

// *** rate_mode_pkg.sv ***
// Register map, field layout and rate constants of the rate and mode control bank.
package rate_mode_pkg;
  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_SYSTEM_CONTROL_ONE = 8'h0A;
  localparam logic [7:0] ADDR_DEVICE_IDENTIFIER  = 8'h0D;
  localparam logic [7:0] ADDR_OUT_X_HIGH         = 8'h01;
  localparam logic [7:0] ADDR_ACCEL_LAST         = 8'h06;
  localparam logic [7:0] ADDR_MAG_FIRST          = 8'h33;
  localparam logic [7:0] ADDR_MAG_LAST           = 8'h38;
  // ---------------------------------------------------------------------------
  // Field positions of system_control_one
  // ---------------------------------------------------------------------------
  localparam int SLEEP_RATE_LSB  = 6;
  localparam int OUT_RATE_LSB    = 3;
  localparam int LOW_NOISE_BIT   = 2;
  localparam int FAST_READ_BIT   = 1;
  localparam int ACTIVE_BIT      = 0;
  localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
  // Arbitrary neutral identifier values.
  localparam logic [7:0] IDENT_PREPROD_DEFAULT = 8'h5A;
  localparam logic [7:0] IDENT_PROD_DEFAULT    = 8'h5B;
  // ---------------------------------------------------------------------------
  // Rate periods in units of 1/64 ms of the internal timebase
  // ---------------------------------------------------------------------------
  localparam int RATE_UNIT_NS    = 15625;
  localparam int CLK_PERIOD_NS   = 25;
  localparam int UNIT_CYCLES     = RATE_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [15:0] OUT_PERIOD_UNITS [8] = '{16'd80, 16'd160, 16'd320, 16'd640,
                                                   16'd1280, 16'd5120, 16'd10240, 16'd40960};
  localparam logic [15:0] SLEEP_PERIOD_UNITS [4] = '{16'd1280, 16'd5120, 16'd10240, 16'd40960};
  // Full scale in low-noise operation, in units of the 1 g step.
  localparam logic [7:0] LOW_NOISE_LIMIT_G = 8'h04;
endpackage

// *** host_model.sv ***
// Host side of the register interface: write, read and burst-start requests.
`timescale 1ns/10ps
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_write,
  output logic            reg_read,
  output logic            burst_start,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial
  begin
    {reg_write, reg_read, burst_start} = 3'h0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // Idle address and data show the inverse of their last value, never a stale copy.
  task automatic req(input logic [2:0] kind, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    #1;
    {reg_write, reg_read, burst_start} = kind;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    q = reg_rdata;
    {reg_write, reg_read, burst_start} = 3'h0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
endmodule // host_model

// *** tb.sv ***
// Self-checking testbench of the rate and mode control bank.
`timescale 1ns/10ps
module tb;
  import rate_mode_pkg::*;
  // Arbitrary identifier values.
  localparam logic [7:0] ID_PRE  = 8'h3C;
  localparam logic [7:0] ID_PROD = 8'h3D;
  logic clk = 1'b0, arst_n = 1'b0, production_part = 1'b0, fifo_mode_zero = 1'b1;
  logic hybrid_mode = 1'b0, hybrid_burst_increment = 1'b0, auto_sleep = 1'b0, clk_en = 1'b1;
  localparam logic [7:0] RATE_CTL [3] = '{8'h00, 8'h40, 8'hF8};
  logic [7:0] sensor_rdata = 8'h00;
  logic reg_write, reg_read, burst_start, active, low_noise, fast_read, sample_tick;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, burst_addr, range_limit_g, q, d, ctl, a;
  int bad_count = 0, checks = 0, n;
  always #12.5 clk = ~clk;
  host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_write(reg_write),
    .reg_read(reg_read), .burst_start(burst_start), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  sensor_rate_mode_control #(.IDENT_PREPROD(ID_PRE), .IDENT_PROD(ID_PROD)) dut (
    .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .production_part(production_part),
    .reg_write(reg_write), .reg_read(reg_read), .burst_start(burst_start),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .sensor_rdata(sensor_rdata),
    .fifo_mode_zero(fifo_mode_zero), .hybrid_mode(hybrid_mode),
    .hybrid_burst_increment(hybrid_burst_increment), .auto_sleep(auto_sleep),
    .reg_rdata(reg_rdata), .burst_addr(burst_addr), .active(active), .low_noise(low_noise),
    .fast_read(fast_read), .range_limit_g(range_limit_g), .sample_tick(sample_tick));
  // ---------------------------------------------------------------------------
  // Checking and verdict
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Expected pointer step, worked out independently of the design.
  function automatic logic [7:0] nxt(input logic [7:0] p, input logic fr);
    if (p == (fr ? 8'h05 : 8'h06))
      return 8'h33;
    if (p == (fr ? 8'h37 : 8'h38))
      return 8'h01;
    return p + (fr ? 8'h02 : 8'h01);
  endfunction
  // Expected period in cycles: 1.25 ms is 50000 cycles, then shifted per table step.
  function automatic logic [31:0] exp_period(input logic [7:0] c, input logic sl,
                                             input logic hy);
    int sh [8];
    sh = '{0, 1, 2, 3, 4, 6, 7, 9};
    return (32'h0000C350 << sh[sl ? {1'b1, c[7:6]} : c[5:3]]) << hy;
  endfunction
  task automatic wr_ctl(input logic [7:0] v, input logic [7:0] exp);
    host.req(3'h4, ADDR_SYSTEM_CONTROL_ONE, v, q);
    host.req(3'h2, ADDR_SYSTEM_CONTROL_ONE, 8'h00, q);
    check(q, exp);
    check(active, exp[0]);
    check(low_noise, exp[2]);
    check(fast_read, exp[1]);
    check(range_limit_g, exp[2] ? 8'h04 : 8'h00);
    ctl = exp;
  endtask
  task automatic do_burst(input logic fr, input int len);
    host.req(3'h1, ADDR_OUT_X_HIGH, 8'h00, q);
    a = ADDR_OUT_X_HIGH;
    repeat (len)
    begin
      sensor_rdata = 8'($urandom);
      host.req(3'h2, ADDR_OUT_X_HIGH, 8'h00, q);
      a = nxt(a, fr);
      check(burst_addr, a);
      check(q, sensor_rdata);
    end
    check(a, ADDR_OUT_X_HIGH);
  endtask
  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h22f7));
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    check({active, low_noise, fast_read, sample_tick}, 4'h0);
    host.req(3'h2, ADDR_SYSTEM_CONTROL_ONE, 8'h00, q);
    check(q, CONTROL_ONE_RESET);
    host.req(3'h4, ADDR_DEVICE_IDENTIFIER, 8'hFF, q);
    host.req(3'h2, ADDR_DEVICE_IDENTIFIER, 8'h00, q);
    check(q, ID_PRE);
    production_part = 1'b1;
    repeat (4) @(posedge clk);
    host.req(3'h2, ADDR_DEVICE_IDENTIFIER, 8'h00, q);
    check(q, ID_PROD);
    $display("test identity done");
    ctl = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      d = 8'($urandom) & 8'hFE;
      fifo_mode_zero = (i < 2) ? i[0] : 1'($urandom);
      wr_ctl(d, {d[7:2], fifo_mode_zero ? d[1] : ctl[1], 1'b0});
    end
    fifo_mode_zero = 1'b1;
    $display("test standby writes done");
    for (int k = 0; k < 3; k++)
    begin
      wr_ctl(RATE_CTL[k], RATE_CTL[k]);
      for (int m = 0; m < 4; m++)
      begin
        @(posedge clk);
        #1 {auto_sleep, hybrid_mode} = 2'(m);
        #1 check(dut.period, exp_period(RATE_CTL[k], m[1], m[0]));
      end
    end
    {auto_sleep, hybrid_mode} = 2'h0;
    clk_en = 1'b0;
    host.req(3'h4, ADDR_SYSTEM_CONTROL_ONE, 8'h00, q);
    clk_en = 1'b1;
    host.req(3'h2, ADDR_SYSTEM_CONTROL_ONE, 8'h00, q);
    check(q, ctl);
    $display("test rate table and enable done");
    hybrid_mode = 1'b1;
    hybrid_burst_increment = 1'b1;
    wr_ctl(8'h02, 8'h02);
    do_burst(1'b1, 6);
    wr_ctl(8'h00, 8'h00);
    do_burst(1'b0, 12);
    hybrid_mode = 1'b0;
    $display("test bursts done");
    repeat (20)
    begin
      @(posedge clk);
      check(sample_tick, 1'b0);
    end
    d = {5'h00, 2'($urandom), 1'b1};
    wr_ctl(d, d);
    n = 0;
    while (sample_tick !== 1'b1 && n < 60000)
    begin
      @(posedge clk);
      #1 n++;
    end
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end
    while (sample_tick !== 1'b1 && n < 60000);
    check(n, 80 * UNIT_CYCLES);
    wr_ctl(8'hFE, d & 8'hFE);
    $display("test active rate done");
    print_verdict();
  end
  initial
  begin
    #(25 * 130000);
    bad_count++;
    print_verdict();
  end
endmodule // tb
